// ### flash_erase_clock_config_map.svh
// Offsets, field positions, reset values and constants of the flash
// erase and clock configuration block.
// Assumes 8-bit byte addresses on the register port.
`ifndef FLASH_ERASE_CLOCK_CONFIG_MAP_SVH
`define FLASH_ERASE_CLOCK_CONFIG_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FECC_ADDR_WIDTH        8
`define FECC_OFS_ERASE_CONTROL 8'h00
`define FECC_OFS_CLOCK_CONFIG  8'h02

// ----------------------------------------------------------------------------
// Password byte
// ----------------------------------------------------------------------------
`define FECC_KEY_MSB           15
`define FECC_KEY_LSB           8
`define FECC_KEY_READ          8'h96
`define FECC_KEY_WRITE         8'ha5

// ----------------------------------------------------------------------------
// Erase control fields
// ----------------------------------------------------------------------------
`define FECC_BIT_EXIT_EN       4
`define FECC_BIT_ERASE_INT_EN  3
`define FECC_BIT_MASS_ERASE    2
`define FECC_BIT_ERASE         1

// ----------------------------------------------------------------------------
// Clock config fields and reset value
// ----------------------------------------------------------------------------
`define FECC_SEL_MSB           7
`define FECC_SEL_LSB           6
`define FECC_DIV_MSB           5
`define FECC_DIV_LSB           0
`define FECC_CLOCK_RESET       8'h42

`endif

// ### flash_erase_clock_config_pkg.sv
// Types shared by the flash erase and clock configuration block.
// Assumes the constants come from flash_erase_clock_config_map.svh.
package flash_erase_clock_config_pkg;

  typedef enum logic [1:0] {
    MODE_NONE    = 2'h0,
    MODE_SEGMENT = 2'h1,
    MODE_MAIN    = 2'h2,
    MODE_ALL     = 2'h3
  } erase_mode_type;

  typedef enum logic [1:0] {
    SRC_AUX       = 2'h0,
    SRC_MAIN      = 2'h1,
    SRC_SUB_MAIN  = 2'h2,
    SRC_SUB_MAIN2 = 2'h3
  } clock_source_type;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_RUN,
    PH_SUSPEND
  } erase_phase_type;

endpackage : flash_erase_clock_config_pkg

// ### timing_divider_if.sv
// Interface between the configuration logic and the timing divider.
// Assumes one clock domain; source ticks are one-cycle enables.
`timescale 1ns/1ps
interface timing_divider_if #(
  parameter int DIV_WIDTH = 6
);
  logic                 src_tick;
  logic [DIV_WIDTH-1:0] divider;
  logic                 timing_tick;

  modport ctrl (output src_tick, output divider, input  timing_tick);
  modport div  (input  src_tick, input  divider, output timing_tick);
endinterface : timing_divider_if

// ### flash_timing_divider.sv
// Divides the selected source enable by divider plus one.
// Assumes src_tick is a one-cycle enable on i_ref_clk.
`timescale 1ns/1ps
module flash_timing_divider #(
  parameter int DIV_WIDTH = 6
) (
  input  wire logic     i_ref_clk,
  input  wire logic     i_resetn,
  timing_divider_if.div bus
);

  if (DIV_WIDTH < 1 || DIV_WIDTH > 16) begin : g_bad_div_width
    $error("DIV_WIDTH out of range");
  end

  typedef struct packed {
    logic [DIV_WIDTH-1:0] count;
    logic                 tick;
  } div_state_type;

  div_state_type st_r;
  div_state_type st_nxt;

  // ----------------------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (bus.src_tick) begin
      if (st_r.count >= bus.divider) begin
        st_nxt.count = '0;
        st_nxt.tick  = 1'b1;
      end else begin
        st_nxt.count = st_r.count + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.timing_tick = st_r.tick;

endmodule : flash_timing_divider

// ### flash_erase_clock_config.sv
// Erase control and timing clock configuration of the flash controller.
// Assumes a sequencer that reports erase activity and an interrupt
// controller that reports pending requests, all on i_ref_clk.
//
// Summary of operation
// - Erase interrupt enable lets interrupts suspend segment erase
// - Suspended segment erase resumes after service
// - Two bits select none, segment, main erase
// - Both bits: lock input picks info erase
// - Emergency exit clears both erase mode bits
// - Key reads 96h, writes need A5h
// - Source select: aux, main, sub main clock
// - Timing clock is source over divider plus one
// - Wrong key write pulses power up clear
// - Exit enable plus interrupts during an operation requests emergency exit
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "flash_erase_clock_config_map.svh"
module flash_erase_clock_config
  import flash_erase_clock_config_pkg::*;
#(
  parameter int DIV_WIDTH = 6
) (
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_resetn,
  input  wire logic [`FECC_ADDR_WIDTH-1:0] i_addr,
  input  wire logic [15:0]                  i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [15:0]                  o_rdata,
  input  wire logic                         i_aux_clk_tick,
  input  wire logic                         i_main_clk_tick,
  input  wire logic                         i_sub_main_clk_tick,
  output logic                              o_timing_clk_tick,
  input  wire logic                         i_segment_info_lock,
  input  wire logic                         i_emergency_exit,
  input  wire logic                         i_global_irq_enable,
  input  wire logic                         i_irq_pending,
  input  wire logic                         i_erase_active,
  input  wire logic                         i_op_active,
  output logic      [1:0]                   o_erase_mode,
  output logic                              o_erase_segment,
  output logic                              o_erase_main,
  output logic                              o_erase_info,
  output logic                              o_irq_hold,
  output logic                              o_erase_suspend,
  output logic                              o_erase_resume,
  output logic                              o_emergency_exit_req,
  output logic                              o_power_up_clear_reset
);

  if (DIV_WIDTH != `FECC_DIV_MSB - `FECC_DIV_LSB + 1) begin : g_bad_div_width
    $error("DIV_WIDTH must match the divider field");
  end

  typedef struct packed {
    logic                 exit_en;
    logic                 erase_int_en;
    logic                 mass_erase;
    logic                 erase;
    clock_source_type     src_sel;
    logic [DIV_WIDTH-1:0] divider;
    logic [15:0]          rdata;
    logic                 power_up_clear_reset;
    logic                 emergency_exit_d;
    erase_phase_type      phase;
    logic                 resume;
    logic                 exit_req;
  } cfg_state_type;

  cfg_state_type st_r;
  cfg_state_type st_nxt;

  timing_divider_if #(.DIV_WIDTH(DIV_WIDTH)) div_bus ();

  function automatic logic key_ok(input logic [15:0] data);
    key_ok = (data[`FECC_KEY_MSB:`FECC_KEY_LSB] == `FECC_KEY_WRITE);
  endfunction : key_ok

  logic           wr_erase;
  logic           wr_clock;
  logic           seg_erase;
  erase_mode_type mode;

  assign wr_erase  = i_wr && (i_addr == `FECC_OFS_ERASE_CONTROL);
  assign wr_clock  = i_wr && (i_addr == `FECC_OFS_CLOCK_CONFIG);
  assign mode      = erase_mode_type'({st_r.mass_erase, st_r.erase});
  assign seg_erase = i_erase_active && (mode == MODE_SEGMENT);

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rdata  = 16'h0000;
    st_nxt.power_up_clear_reset    = 1'b0;
    st_nxt.resume = 1'b0;
    st_nxt.emergency_exit_d = i_emergency_exit;

    if (wr_erase && key_ok(i_wdata)) begin
      st_nxt.exit_en      = i_wdata[`FECC_BIT_EXIT_EN];
      st_nxt.erase_int_en = i_wdata[`FECC_BIT_ERASE_INT_EN];
      st_nxt.mass_erase   = i_wdata[`FECC_BIT_MASS_ERASE];
      st_nxt.erase        = i_wdata[`FECC_BIT_ERASE];
    end
    if (wr_clock && key_ok(i_wdata)) begin
      st_nxt.src_sel = clock_source_type'(i_wdata[`FECC_SEL_MSB:`FECC_SEL_LSB]);
      st_nxt.divider = i_wdata[`FECC_DIV_MSB:`FECC_DIV_LSB];
    end

    if ((wr_erase || wr_clock) && !key_ok(i_wdata)) begin
      st_nxt.power_up_clear_reset = 1'b1;
    end

    if (i_emergency_exit && !st_r.emergency_exit_d) begin
      st_nxt.mass_erase = 1'b0;
      st_nxt.erase      = 1'b0;
      st_nxt.exit_en    = 1'b0;
    end

    st_nxt.exit_req = st_r.exit_en && i_global_irq_enable && i_irq_pending && i_op_active;

    unique case (st_r.phase)
      PH_IDLE: begin
        if (seg_erase) begin
          st_nxt.phase = PH_RUN;
        end
      end
      PH_RUN: begin
        if (!seg_erase) begin
          st_nxt.phase = PH_IDLE;
        end else if (st_r.erase_int_en && i_irq_pending) begin
          st_nxt.phase = PH_SUSPEND;
        end
      end
      PH_SUSPEND: begin
        if (mode != MODE_SEGMENT) begin
          st_nxt.phase = PH_IDLE;
        end else if (!i_irq_pending) begin
          st_nxt.phase  = PH_RUN;
          st_nxt.resume = 1'b1;
        end
      end
    endcase

    if (i_rd && i_addr == `FECC_OFS_ERASE_CONTROL) begin
      st_nxt.rdata = {`FECC_KEY_READ, 3'h0, st_r.exit_en, st_r.erase_int_en,
                      st_r.mass_erase, st_r.erase, 1'b0};
    end else if (i_rd && i_addr == `FECC_OFS_CLOCK_CONFIG) begin
      st_nxt.rdata = {`FECC_KEY_READ, st_r.src_sel, st_r.divider};
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      st_r         <= '0;
      st_r.src_sel <= clock_source_type'(2'(`FECC_CLOCK_RESET >> `FECC_SEL_LSB));
      st_r.divider <= DIV_WIDTH'(`FECC_CLOCK_RESET);
      st_r.phase   <= PH_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Timing clock source and divider
  // ----------------------------------------------------------------------------
  always_comb begin
    unique case (st_r.src_sel)
      SRC_AUX:  div_bus.src_tick = i_aux_clk_tick;
      SRC_MAIN: div_bus.src_tick = i_main_clk_tick;
      default:  div_bus.src_tick = i_sub_main_clk_tick;
    endcase
  end

  assign div_bus.divider = st_r.divider;

  flash_timing_divider #(
    .DIV_WIDTH (DIV_WIDTH)
  ) u_divider (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .bus       (div_bus.div)
  );

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign o_timing_clk_tick = div_bus.timing_tick;
  assign o_rdata           = st_r.rdata;
  assign o_erase_mode      = mode;
  assign o_erase_segment   = (mode == MODE_SEGMENT);
  assign o_erase_main      = mode[1];
  assign o_erase_info      = (mode == MODE_ALL) && !i_segment_info_lock;
  assign o_irq_hold        = seg_erase && !st_r.erase_int_en;
  assign o_erase_suspend   = (st_r.phase == PH_SUSPEND);
  assign o_erase_resume    = st_r.resume;
  assign o_emergency_exit_req   = st_r.exit_req;
  assign o_power_up_clear_reset = st_r.power_up_clear_reset;

endmodule : flash_erase_clock_config

// ### flash_erase_clock_config_chk.sv
// Port-level checker of the flash erase and clock configuration block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module flash_erase_clock_config_chk
  import flash_erase_clock_config_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire logic [7:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        i_segment_info_lock,
  input wire logic        i_emergency_exit,
  input wire logic        i_global_irq_enable,
  input wire logic        i_irq_pending,
  input wire logic        i_op_active,
  input wire logic [1:0]  o_erase_mode,
  input wire logic        o_erase_segment,
  input wire logic        o_erase_info,
  input wire logic        o_irq_hold,
  input wire logic        o_erase_suspend,
  input wire logic        o_erase_resume,
  input wire logic        o_emergency_exit_req,
  input wire logic        o_power_up_clear_reset
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence mapped_read_s;
    i_rd && (i_addr == 8'h00 || i_addr == 8'h02);
  endsequence
  sequence bad_write_s;
    i_wr && i_wdata[15:8] != 8'ha5 && (i_addr == 8'h00 || i_addr == 8'h02);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_segment_decode: assert property (o_erase_segment == (o_erase_mode == 2'h1))
    else $error("segment decode wrong");
  a_info_lock: assert property (o_erase_info == (o_erase_mode == 2'h3 && !i_segment_info_lock))
    else $error("info erase decode wrong");
  a_exit_clears: assert property ($rose(i_emergency_exit) |=> o_erase_mode == 2'h0)
    else $error("erase mode not cleared by exit");
  a_key_readback: assert property (mapped_read_s |=> o_rdata[15:8] == 8'h96)
    else $error("password byte readback wrong");
  a_bad_key_reset: assert property (bad_write_s |=> o_power_up_clear_reset)
    else $error("bad key gave no reset pulse");
  a_reset_cause: assert property (o_power_up_clear_reset |-> $past(i_wr) && $past(i_wdata[15:8]) != 8'ha5)
    else $error("reset pulse without bad key");
  a_bit0_zero: assert property (i_rd |=> !o_rdata[0])
    else $error("reserved bit reads one");
  a_hold_segment: assert property (o_irq_hold |-> o_erase_mode == 2'h1)
    else $error("irq hold outside segment erase");
  a_suspend_cause: assert property ($rose(o_erase_suspend) |-> $past(i_irq_pending))
    else $error("suspend without interrupt");
  a_resume_mode: assert property (o_erase_resume |-> $fell(o_erase_suspend) && o_erase_mode == 2'h1)
    else $error("resume without suspend end");
  a_exit_request: assert property (o_emergency_exit_req |-> $past(i_op_active && i_global_irq_enable && i_irq_pending))
    else $error("exit request without cause");
endmodule : flash_erase_clock_config_chk

bind flash_erase_clock_config flash_erase_clock_config_chk chk (.i_ref_clk, .i_resetn, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_segment_info_lock, .i_emergency_exit, .i_global_irq_enable,
  .i_irq_pending, .i_op_active, .o_erase_mode, .o_erase_segment, .o_erase_info, .o_irq_hold,
  .o_erase_suspend, .o_erase_resume, .o_emergency_exit_req, .o_power_up_clear_reset);

// ### tb_top.sv
// Self-checking testbench of the flash erase and clock configuration block.
// Assumes a 100 MHz clock and the plain register port of the block.
`timescale 1ns/1ps
module tb_top
  import flash_erase_clock_config_pkg::*;
;
  logic        i_ref_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000, o_rdata;
  logic        i_aux_clk_tick = 1'b0, i_main_clk_tick = 1'b0, i_sub_main_clk_tick = 1'b0;
  logic        i_segment_info_lock = 1'b0, i_emergency_exit = 1'b0, i_global_irq_enable = 1'b0;
  logic        i_irq_pending = 1'b0, i_erase_active = 1'b0, i_op_active = 1'b0;
  logic [1:0]  o_erase_mode, tc = 2'h0;
  logic        o_timing_clk_tick, o_erase_segment, o_erase_main, o_erase_info, o_irq_hold;
  logic        o_erase_suspend, o_erase_resume, o_emergency_exit_req, o_power_up_clear_reset;
  int          error_cnt = 0, checked = 0, cyc = 0, n;

  flash_erase_clock_config DUT (.i_ref_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_aux_clk_tick, .i_main_clk_tick, .i_sub_main_clk_tick, .o_timing_clk_tick, .i_segment_info_lock,
    .i_emergency_exit, .i_global_irq_enable, .i_irq_pending, .i_erase_active, .i_op_active, .o_erase_mode,
    .o_erase_segment, .o_erase_main, .o_erase_info, .o_irq_hold, .o_erase_suspend, .o_erase_resume,
    .o_emergency_exit_req, .o_power_up_clear_reset);

  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  // ----------------------------------------------------------------
  // Source ticks every 1, 2 and 4 cycles; run limit
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    tc <= tc + 2'h1;
    i_aux_clk_tick <= 1'b1;
    i_main_clk_tick <= tc[0];
    i_sub_main_clk_tick <= (tc == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask : cmp16
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp1
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 cmp16(o_rdata, exp);
  endtask : rd
  task automatic period(input logic [1:0] s, input logic [5:0] d, input int exp);
    wr(8'h02, {8'ha5, s, d});
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge i_ref_clk);
        #1 n++;
      end while (!o_timing_clk_tick && n < 600);
    end
    cmp16(16'(n), 16'(exp));
  endtask : period
  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rd(8'h02, 16'h9642);
    rd(8'h00, 16'h9600);
    rd(8'h04, 16'h0000);
    wr(8'h00, 16'ha51f);
    rd(8'h00, 16'h961e);
    cmp1(o_erase_info, 1'b1);
    @(posedge i_ref_clk) i_segment_info_lock <= 1'b1;
    @(posedge i_ref_clk) #1 cmp1(o_erase_info, 1'b0);
    wr(8'h00, 16'h5a00);
    cmp1(o_power_up_clear_reset, 1'b1);
    wr(8'h02, 16'h1201);
    rd(8'h00, 16'h961e);
    rd(8'h02, 16'h9642);
    @(posedge i_ref_clk) i_emergency_exit <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1 cmp16({14'h0, o_erase_mode}, 16'h0000);
    rd(8'h00, 16'h9608);
    @(posedge i_ref_clk) i_emergency_exit <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      wr(8'h00, 16'ha500 | 16'(m << 1));
      cmp1(o_erase_segment, m == 1);
      cmp1(o_erase_main, m == 2);
    end
    wr(8'h00, 16'ha50a);
    @(posedge i_ref_clk) i_erase_active <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_irq_pending <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 cmp1(o_erase_suspend, 1'b1);
    @(posedge i_ref_clk) i_irq_pending <= 1'b0;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      #1 n++;
    end while (!o_erase_resume && n < 4);
    cmp1(o_erase_resume, 1'b1);
    cmp16({14'h0, o_erase_mode}, 16'h0001);
    wr(8'h00, 16'ha502);
    cmp1(o_irq_hold, 1'b1);
    @(posedge i_ref_clk) i_irq_pending <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 cmp1(o_erase_suspend, 1'b0);
    wr(8'h00, 16'ha512);
    @(posedge i_ref_clk) i_erase_active <= 1'b0;
    i_op_active <= 1'b1;
    i_global_irq_enable <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    #1 cmp1(o_emergency_exit_req, 1'b1);
    @(posedge i_ref_clk) i_global_irq_enable <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1 cmp1(o_emergency_exit_req, 1'b0);
    period(2'h0, 6'h02, 3);
    period(2'h1, 6'h02, 6);
    period(2'h2, 6'h00, 4);
    period(2'h3, 6'h3f, 256);
    period(2'h0, 6'h00, 1);
    print_verdict();
  end
endmodule : tb_top
